// [tcs_defs.svh]
// Offsets, field positions and reset values of the timer channel.
// Assumes a byte-addressed register port with one 32-bit word each.
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH
// Register offsets
`define TCS_OFS_CTRL      8'h00
`define TCS_OFS_MODE      8'h04
`define TCS_OFS_COUNT     8'h10
`define TCS_OFS_CAPA      8'h14
`define TCS_OFS_CAPB      8'h18
`define TCS_OFS_PERIOD    8'h1C
`define TCS_OFS_STATUS    8'h20
`define TCS_OFS_IRQ_SET   8'h24
`define TCS_OFS_IRQ_CLR   8'h28
`define TCS_OFS_IRQ_MASK  8'h2C
// Control register bits
`define TCS_CTRL_CLK_EN   0
`define TCS_CTRL_CLK_DIS  1
`define TCS_CTRL_SWTRIG   2
// Mode register fields
`define TCS_MODE_WAVE     15
`define TCS_MODE_CPB_LO   24
`define TCS_MODE_CPC_LO   26
`define TCS_MODE_EVT_LO   28
`define TCS_MODE_SWT_LO   30
// Status register bits
`define TCS_ST_OVF        0
`define TCS_ST_OVR        1
`define TCS_ST_MTA        2
`define TCS_ST_MTB        3
`define TCS_ST_MTC        4
`define TCS_ST_LDA        5
`define TCS_ST_LDB        6
`define TCS_ST_ETR        7
`define TCS_ST_CLK        16
`define TCS_ST_MIRA       17
`define TCS_ST_MIRB       18
// Reset values and counter maximum
`define TCS_RST_COUNT     16'h0000
`define TCS_RST_CAP       16'h0000
`define TCS_RST_PERIOD    16'h0000
`define TCS_RST_FLAGS     8'h00
`define TCS_RST_MASK      8'h00
`define TCS_MAX_COUNT     16'hFFFF
`endif

// [tcs_pkg.sv]
// Types shared by the timer channel.
// Assumes tcs_defs.svh supplies all numeric constants.
package tcs_pkg;
  // Effect of an event on the second output line
  typedef enum logic [1:0] {
    TCS_EFF_NONE   = 2'h0,
    TCS_EFF_SET    = 2'h1,
    TCS_EFF_CLEAR  = 2'h2,
    TCS_EFF_TOGGLE = 2'h3
  } tcs_effect_e;
  // Counter and compare word
  typedef logic [15:0] tcs_word_t;
  // Eight sticky status flags
  typedef logic [7:0]  tcs_flags_t;
endpackage : tcs_pkg

// [tcs_channel.sv]
// One 16-bit timer/counter channel with its status and compare registers.
// Assumes a single 100 MHz clock, a plain register port and pins that
// come from outside the clock domain.
`timescale 1ns/1ps
`include "tcs_defs.svh"
`default_nettype none

module tcs_channel
  import tcs_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  output logic      [31:0] o_rd_data,
  // First I/O line
  input  wire logic        i_line_a,
  output logic             o_line_a,
  output logic             o_line_a_oe,
  // Second I/O line
  input  wire logic        i_line_b,
  output logic             o_line_b,
  output logic             o_line_b_oe,
  // External event source
  input  wire logic        i_ext_evt,
  // Interrupt request
  output logic             o_irq
);

  // The same decode serves all four line_b sources, so a change to
  // the effect encoding needs touching in one place only
  // Applies a two-bit effect to a line level
  function automatic logic apply_eff(input tcs_effect_e eff,
                                     input logic lvl);
    case (eff)
      TCS_EFF_SET:    apply_eff = 1'b1;
      TCS_EFF_CLEAR:  apply_eff = 1'b0;
      TCS_EFF_TOGGLE: apply_eff = ~lvl;
      default:        apply_eff = lvl;
    endcase
  endfunction : apply_eff

  // Pins are asynchronous; a level is believed only after it has
  // stood still for two samples in a row, which filters glitches
  // Three-stage synchronisers: index 0 line_a, 1 line_b, 2 event
  logic [2:0]  sync1_q, sync2_q, sync3_q;
  logic [2:0]  filt_q,  filt_d;       // Accepted pin levels
  // Counter and its clock gate
  tcs_word_t   count_q, count_d;
  logic        run_q,   run_d;        // Counter clock enabled
  // Capture/compare registers
  tcs_word_t   cap_a_q, cap_a_d;
  tcs_word_t   cap_b_q, cap_b_d;
  tcs_word_t   per_q,   per_d;
  logic        unrd_a_q, unrd_a_d;    // A loaded, not yet read
  logic        unrd_b_q, unrd_b_d;    // B loaded, not yet read
  // Mode fields
  // A mode write takes all fields at once; there is no partial update
  logic        wave_q,  wave_d;
  tcs_effect_e eff_cpb_q, eff_cpb_d;
  tcs_effect_e eff_cpc_q, eff_cpc_d;
  tcs_effect_e eff_evt_q, eff_evt_d;
  tcs_effect_e eff_swt_q, eff_swt_d;
  // Status, mask and outputs
  tcs_flags_t  flags_q, flags_d;
  tcs_flags_t  mask_q,  mask_d;
  logic        line_b_q, line_b_d;    // Driven level of line_b
  logic [31:0] rdata_q, rdata_d;
  logic        irq_q,   irq_d;

  // Decoded accesses
  logic wr_ctrl, wr_mode, wr_capa, wr_capb, wr_per, wr_set, wr_clr;
  logic rd_st, rd_capa, rd_capb;
  // Events of this cycle
  logic ev_ovf, ev_mta, ev_mtb, ev_mtc, ev_lda, ev_ldb, ev_ext, ev_swt;
  tcs_flags_t set_v;
  logic [31:0] status_v;

  // Synchroniser chain; only stage 2 reads stage 1
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
    end else begin
      sync1_q <= {i_ext_evt, i_line_b, i_line_a};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A level change counts only once stages 2 and 3 agree
  // One identical copy per synchronised input
  generate
    for (genvar g = 0; g < 3; g++) begin : g_filt
      always_comb begin
        filt_d[g] = (sync2_q[g] == sync3_q[g]) ? sync3_q[g] : filt_q[g];
      end
    end
  endgenerate

  // Addresses are compared in full; no register has an alias, so
  // stray accesses land on nothing
  // Address decode of the register port
  always_comb begin
    wr_ctrl = i_wr_en && (i_addr == `TCS_OFS_CTRL);
    wr_mode = i_wr_en && (i_addr == `TCS_OFS_MODE);
    wr_capa = i_wr_en && (i_addr == `TCS_OFS_CAPA);
    wr_capb = i_wr_en && (i_addr == `TCS_OFS_CAPB);
    wr_per  = i_wr_en && (i_addr == `TCS_OFS_PERIOD);
    wr_set  = i_wr_en && (i_addr == `TCS_OFS_IRQ_SET);
    wr_clr  = i_wr_en && (i_addr == `TCS_OFS_IRQ_CLR);
    rd_st   = i_rd_en && (i_addr == `TCS_OFS_STATUS);
    rd_capa = i_rd_en && (i_addr == `TCS_OFS_CAPA);
    rd_capb = i_rd_en && (i_addr == `TCS_OFS_CAPB);
  end

  // Compares are qualified by the clock gate so that a stopped counter
  // resting on a compare value does not raise its flag every cycle.
  // Overflow is seen in the last count before the wrap to zero.
  // Event detection; compares look at the count while it is running
  always_comb begin
    ev_swt = wr_ctrl && i_wr_data[`TCS_CTRL_SWTRIG];
    ev_ovf = run_q && (count_q == `TCS_MAX_COUNT);
    ev_mta = run_q && (count_q == cap_a_q);
    ev_mtb = run_q && (count_q == cap_b_q);
    ev_mtc = run_q && (count_q == per_q);
    // Capture loads: rising edge of line_a into A, falling into B
    ev_lda = !wave_q && filt_d[0] && !filt_q[0];
    ev_ldb = !wave_q && !filt_d[0] && filt_q[0];
    // Rising edge of the event input is the external trigger
    ev_ext = filt_d[2] && !filt_q[2];
  end

  // Mode gating is applied twice: here for the set term, and below
  // for flags left over from before a mode change
  // Flags that hardware sets this cycle, gated by the mode
  always_comb begin
    set_v = 8'h00;
    set_v[`TCS_ST_OVF] = ev_ovf;
    set_v[`TCS_ST_OVR] = (ev_lda && unrd_a_q) || (ev_ldb && unrd_b_q);
    set_v[`TCS_ST_MTA] = wave_q && ev_mta;
    set_v[`TCS_ST_MTB] = wave_q && ev_mtb;
    set_v[`TCS_ST_MTC] = ev_mtc;
    set_v[`TCS_ST_LDA] = ev_lda;
    set_v[`TCS_ST_LDB] = ev_ldb;
    set_v[`TCS_ST_ETR] = ev_ext;
  end

  // Live status word, also the source of the read mux
  // Bits 15:8 and above 18 are reserved and read zero; a status read
  // never disturbs bits 16 to 18
  always_comb begin
    status_v = 32'h0000_0000;
    status_v[7:0] = flags_q;
    status_v[`TCS_ST_CLK] = run_q;
    // Waveform shows the driven level, capture the pin level
    status_v[`TCS_ST_MIRA] = wave_q ? 1'b0 : filt_q[0];
    status_v[`TCS_ST_MIRB] = wave_q ? line_b_q : filt_q[1];
  end

  // Next state of counter, registers, flags and outputs
  always_comb begin
    // Counter clock gate; disable wins over enable in one write
    run_d = run_q;
    if (wr_ctrl && i_wr_data[`TCS_CTRL_CLK_EN]) begin
      run_d = 1'b1;
    end
    if (wr_ctrl && i_wr_data[`TCS_CTRL_CLK_DIS]) begin
      run_d = 1'b0;
    end
    // Limitation: the counter steps on every reference clock; clock
    // selection and prescaling live outside this channel.
    // A software trigger zeroes the count but leaves the clock gate.
    // Counter wraps naturally at overflow
    count_d = count_q;
    if (ev_swt) begin
      count_d = `TCS_RST_COUNT;
    end else if (run_q) begin
      count_d = count_q + 16'h0001;
    end

    // Mode register fields
    wave_d    = wave_q;
    eff_cpb_d = eff_cpb_q;
    eff_cpc_d = eff_cpc_q;
    eff_evt_d = eff_evt_q;
    eff_swt_d = eff_swt_q;
    if (wr_mode) begin
      wave_d    = i_wr_data[`TCS_MODE_WAVE];
      eff_cpb_d = tcs_effect_e'(i_wr_data[`TCS_MODE_CPB_LO +: 2]);
      eff_cpc_d = tcs_effect_e'(i_wr_data[`TCS_MODE_CPC_LO +: 2]);
      eff_evt_d = tcs_effect_e'(i_wr_data[`TCS_MODE_EVT_LO +: 2]);
      eff_swt_d = tcs_effect_e'(i_wr_data[`TCS_MODE_SWT_LO +: 2]);
    end

    // Software write and pin load never compete: writes are legal only
    // in waveform mode, where pin loads are switched off
    // Capture A: software in waveform mode, pin edge in capture mode
    cap_a_d = cap_a_q;
    if (wr_capa && wave_q) begin
      cap_a_d = i_wr_data[15:0];
    end else if (ev_lda) begin
      cap_a_d = count_q;
    end
    cap_b_d = cap_b_q;
    if (wr_capb && wave_q) begin
      cap_b_d = i_wr_data[15:0];
    end else if (ev_ldb) begin
      cap_b_d = count_q;
    end
    per_d = per_q;
    if (wr_per) begin
      per_d = i_wr_data[15:0];
    end

    // Unread tracking; a load in the read cycle stays unread
    // Each register read clears only its own unread marker
    unrd_a_d = wave_q ? 1'b0 : (ev_lda || (unrd_a_q && !rd_capa));
    unrd_b_d = wave_q ? 1'b0 : (ev_ldb || (unrd_b_q && !rd_capb));

    // Trade-off: an event in the read cycle is reported on the next
    // read rather than lost, at the cost of one stale-looking read
    // Sticky flags: a set in the read cycle wins over the clear
    flags_d = (rd_st ? `TCS_RST_FLAGS : flags_q) | set_v;
    // Flags not valid for the current mode read zero
    if (wave_q) begin
      flags_d[`TCS_ST_OVR] = 1'b0;
      flags_d[`TCS_ST_LDA] = 1'b0;
      flags_d[`TCS_ST_LDB] = 1'b0;
    end else begin
      flags_d[`TCS_ST_MTA] = 1'b0;
      flags_d[`TCS_ST_MTB] = 1'b0;
    end

    // Mask: enable sets, disable clears; disable wins if both
    // The mask gates only the request, never the setting of flags
    mask_d = mask_q;
    if (wr_set) begin
      mask_d = mask_d | i_wr_data[7:0];
    end
    if (wr_clr) begin
      mask_d = mask_d & ~i_wr_data[7:0];
    end
    irq_d = |(flags_q & mask_q);

    // Line B effects, lowest priority first so later ones win
    // Each effect sees the result of those before it, so a set and
    // a later toggle in one cycle leave the line low
    line_b_d = line_b_q;
    if (wave_q) begin
      if (ev_mtb) begin
        line_b_d = apply_eff(eff_cpb_q, line_b_d);
      end
      if (ev_mtc) begin
        line_b_d = apply_eff(eff_cpc_q, line_b_d);
      end
      if (ev_ext) begin
        line_b_d = apply_eff(eff_evt_q, line_b_d);
      end
      if (ev_swt) begin
        line_b_d = apply_eff(eff_swt_q, line_b_d);
      end
    end

    // Read mux; unmapped and write-only offsets read zero
    // Read data are registered and cleared when there is no read, so
    // the port shows zero outside the answer cycle
    rdata_d = 32'h0000_0000;
    if (i_rd_en) begin
      case (i_addr)
        `TCS_OFS_MODE: begin
          rdata_d[`TCS_MODE_WAVE]       = wave_q;
          rdata_d[`TCS_MODE_CPB_LO +: 2] = eff_cpb_q;
          rdata_d[`TCS_MODE_CPC_LO +: 2] = eff_cpc_q;
          rdata_d[`TCS_MODE_EVT_LO +: 2] = eff_evt_q;
          rdata_d[`TCS_MODE_SWT_LO +: 2] = eff_swt_q;
        end
        `TCS_OFS_COUNT:    rdata_d[15:0] = count_q;
        `TCS_OFS_CAPA:     rdata_d[15:0] = cap_a_q;
        `TCS_OFS_CAPB:     rdata_d[15:0] = cap_b_q;
        `TCS_OFS_PERIOD:   rdata_d[15:0] = per_q;
        `TCS_OFS_STATUS:   rdata_d       = status_v;
        `TCS_OFS_IRQ_MASK: rdata_d[7:0]  = mask_q;
        default:           rdata_d       = 32'h0000_0000;
      endcase
    end
  end

  // State registers only; all decisions are made above
  // Reset is synchronous and loads constants only
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      filt_q    <= 3'h0;
      count_q   <= `TCS_RST_COUNT;
      run_q     <= 1'b0;
      cap_a_q   <= `TCS_RST_CAP;
      cap_b_q   <= `TCS_RST_CAP;
      per_q     <= `TCS_RST_PERIOD;
      unrd_a_q  <= 1'b0;
      unrd_b_q  <= 1'b0;
      wave_q    <= 1'b0;
      eff_cpb_q <= TCS_EFF_NONE;
      eff_cpc_q <= TCS_EFF_NONE;
      eff_evt_q <= TCS_EFF_NONE;
      eff_swt_q <= TCS_EFF_NONE;
      flags_q   <= `TCS_RST_FLAGS;
      mask_q    <= `TCS_RST_MASK;
      line_b_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      irq_q     <= 1'b0;
    end else begin
      filt_q    <= filt_d;
      count_q   <= count_d;
      run_q     <= run_d;
      cap_a_q   <= cap_a_d;
      cap_b_q   <= cap_b_d;
      per_q     <= per_d;
      unrd_a_q  <= unrd_a_d;
      unrd_b_q  <= unrd_b_d;
      wave_q    <= wave_d;
      eff_cpb_q <= eff_cpb_d;
      eff_cpc_q <= eff_cpc_d;
      eff_evt_q <= eff_evt_d;
      eff_swt_q <= eff_swt_d;
      flags_q   <= flags_d;
      mask_q    <= mask_d;
      line_b_q  <= line_b_d;
      rdata_q   <= rdata_d;
      irq_q     <= irq_d;
    end
  end

  // Output drive; line_a has no waveform logic here and drives low
  // Both enables follow the mode bit: the lines are outputs only in
  // waveform mode and stay inputs for capture and event sensing
  always_comb begin
    o_rd_data   = rdata_q;
    o_irq       = irq_q;
    o_line_a    = 1'b0;
    o_line_a_oe = wave_q;
    o_line_b    = line_b_q;
    o_line_b_oe = wave_q;
  end

endmodule : tcs_channel
`default_nettype wire

// [tcs_chan_chk_asserts.sv]
// Checker for the timer channel register port, line_b enable and irq.
// Assumes it is bound to tcs_channel and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tcs_chan_chk (
  // Clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst_n,
  // Register port
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic        i_wr_en,
  input wire logic        i_rd_en,
  input wire logic [31:0] o_rd_data,
  // Outputs watched
  input wire logic        o_line_b_oe,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic       wave_q, wave_d; // Shadow of the mode bit
  logic       run_q, run_d;   // Shadow of the counter clock state
  logic [7:0] mask_q, mask_d; // Shadow of the interrupt mask
  logic       ctl;            // Control register write
  // Shadows follow writes; disable wins over enable
  always_comb begin
    ctl    = i_wr_en && i_addr == 8'h00;
    wave_d = (i_wr_en && i_addr == 8'h04) ? i_wr_data[15] : wave_q;
    run_d  = (run_q || (ctl && i_wr_data[0])) && !(ctl && i_wr_data[1]);
    mask_d = mask_q;
    if (i_wr_en && i_addr == 8'h24) mask_d = mask_q | i_wr_data[7:0];
    if (i_wr_en && i_addr == 8'h28) mask_d = mask_q & ~i_wr_data[7:0];
  end
  // Synchronous reset, as in the channel, so shadows never lead it
  always_ff @(posedge i_ref_clk) begin
    wave_q <= i_rst_n && wave_d;
    run_q  <= i_rst_n && run_d;
    mask_q <= i_rst_n ? mask_d : 8'h00;
  end
  a_count_step: assert property (
    i_rd_en && i_addr == 8'h10 && run_q ##1 i_rd_en && i_addr == 8'h10
    |=> o_rd_data == {16'h0, $past(o_rd_data[15:0]) + 16'h1})
    else $error("counter reads do not step by one");
  a_period_back: assert property (
    i_wr_en && i_addr == 8'h1C ##1 i_rd_en && i_addr == 8'h1C
    |=> o_rd_data == {16'h0, $past(i_wr_data[15:0], 2)})
    else $error("period register read back wrong");
  a_oe_mode: assert property (
    i_wr_en && i_addr == 8'h04 |-> ##2 o_line_b_oe == $past(i_wr_data[15], 2))
    else $error("line_b enable does not follow mode bit");
  a_irq_masked: assert property ($past(mask_q) == 8'h00 |-> !o_irq)
    else $error("irq raised with all sources masked");
  a_mask_read: assert property (
    i_rd_en && i_addr == 8'h2C |=> o_rd_data == {24'h0, $past(mask_q)})
    else $error("mask register read wrong");
  a_capt_flags: assert property (
    i_rd_en && i_addr == 8'h20 && !wave_q && !$past(wave_q)
    |=> o_rd_data[3:2] == 2'h0) else $error("match flags set in capture");
  a_wave_flags: assert property (
    i_rd_en && i_addr == 8'h20 && wave_q && $past(wave_q)
    |=> o_rd_data[6:5] == 2'h0 && !o_rd_data[1])
    else $error("load flags set in waveform");
  a_clk_status: assert property (
    i_rd_en && i_addr == 8'h20 |=> o_rd_data[16] == $past(run_q))
    else $error("clock status bit wrong");
endmodule : tcs_chan_chk
bind tcs_channel tcs_chan_chk u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .o_rd_data(o_rd_data), .o_line_b_oe(o_line_b_oe), .o_irq(o_irq));
`default_nettype wire

// [tcs_far_pins.sv]
// Far-side model of the two timer lines and the external event source.
// Assumes the bench asks for levels; shared lines resolve by enables.
`timescale 1ns/1ps
`default_nettype none
module tcs_far_pins (
  // Clock and bench requests
  input  wire logic i_ref_clk,
  input  wire logic i_req_a,
  input  wire logic i_req_evt,
  // Device drive of both lines
  input  wire logic i_drv_a,
  input  wire logic i_drv_a_oe,
  input  wire logic i_drv_b,
  input  wire logic i_drv_b_oe,
  // Levels at the device pins
  output logic      o_line_a,
  output logic      o_line_b,
  output logic      o_evt
);
  logic own_b = 1'b0; // Changes every cycle so stale samples show up
  always @(posedge i_ref_clk) own_b <= !own_b;
  // The device owns a line while it enables its driver
  assign o_line_a = i_drv_a_oe ? i_drv_a : i_req_a;
  assign o_line_b = i_drv_b_oe ? i_drv_b : own_b;
  assign o_evt    = i_req_evt;
endmodule : tcs_far_pins
`default_nettype wire

// [timer_channel_status_regs_test.sv]
// Self-checking bench for the timer channel with its far-side pins.
// Assumes tcs_channel, tcs_far_pins and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_status_regs_test;
  typedef struct {logic [7:0] a; logic [31:0] m; logic [31:0] e;} tcs_rd_s;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic        req_a = 1'b0, req_evt = 1'b0;
  logic        lb = 1'b0;    // Expected line_b level
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rnd;          // Random word for capture_a
  wire         line_a, line_b, evt, drv_a, drv_a_oe, drv_b, drv_b_oe, irq;
  wire  [31:0] rdata;
  int          failures = 0, n_tests = 0, seed = 48520;
  tcs_rd_s     pend[$];      // Reads in flight, oldest first
  logic [7:0]  rst_tbl [8] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24,
                               8'h2C, 8'h3C};
  always #5 clk = ~clk;
  tcs_channel DUT (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata), .i_line_a(line_a),
    .o_line_a(drv_a), .o_line_a_oe(drv_a_oe), .i_line_b(line_b),
    .o_line_b(drv_b), .o_line_b_oe(drv_b_oe), .i_ext_evt(evt), .o_irq(irq));
  tcs_far_pins u_far (
    .i_ref_clk(clk), .i_req_a(req_a), .i_req_evt(req_evt), .i_drv_a(drv_a),
    .i_drv_a_oe(drv_a_oe), .i_drv_b(drv_b), .i_drv_b_oe(drv_b_oe),
    .o_line_a(line_a), .o_line_b(line_b), .o_evt(evt));
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // One-cycle write, then an idle cycle so strobes never collide
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask : wr32
  // n back-to-back reads; each notes the masked value it expects
  task automatic rd32(input logic [7:0] a, input logic [31:0] m, e,
                      input int n = 1);
    repeat (n) begin
      rd <= 1'b1;
      addr <= a;
      pend.push_back('{a, m, e});
      @(posedge clk);
    end
    rd <= 1'b0;
    @(posedge clk);
  endtask : rd32
  // Write immediately followed by a read of the same place
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d, e);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk) wr <= 1'b0;
    rd32(a, 32'hFFFFFFFF, e);
  endtask : wrrd
  // Arms one effect field, restarts the counter, fires an event and
  // checks line_b through its status mirror
  task automatic fx(input int sh, input logic [1:0] e);
    wr32(8'h04, 32'h8000 | (32'(e) << sh));
    wr32(8'h00, 32'h5);
    req_evt <= 1'b1;
    repeat (2) @(posedge clk);
    req_evt <= 1'b0;
    repeat (16) @(posedge clk);
    lb = (e == 2'h1) || (e == 2'h3 && !lb) || (e == 2'h0 && lb);
    chk("line_b drive", {31'h0, drv_b}, {31'h0, lb});
    chk("line enables", {29'h0, drv_a, drv_a_oe, drv_b_oe}, 32'h3);
    rd32(8'h20, 32'h40080, 32'h80 | (32'(lb) << 18));
  endtask : fx
  // Read answers stand one cycle after the strobe; compare mid-cycle
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q) begin
      chk($sformatf("register %h", pend[0].a), rdata & pend[0].m,
          pend[0].e & pend[0].m);
      pend.pop_front();
    end
  end
  // Run needs about 66000 cycles; the margin covers the slow steps
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rd32(rst_tbl[i], 32'hFFFFFFFF, 32'h0);
    $display("test reset values done");
    rnd = $random(seed);
    wrrd(8'h14, 32'h1234, 32'h0);
    wrrd(8'h1C, ~rnd, ~rnd & 32'hFFFF);
    wr32(8'h04, 32'h8000);
    wrrd(8'h14, rnd, rnd & 32'hFFFF);
    wrrd(8'h18, 32'h5, 32'h5);
    wrrd(8'h1C, 32'h9, 32'h9);
    for (int s = 24; s < 32; s += 2)
      for (int e = 0; e < 4; e++) fx(s, 2'(e));
    $display("test line_b effects done");
    rd32(8'h20, 32'h70080, 32'h10000 | (32'(lb) << 18));
    wr32(8'h24, 32'hFF);
    wr32(8'h28, 32'hEF);
    rd32(8'h2C, 32'hFFFFFFFF, 32'h10);
    wr32(8'h00, 32'h5);
    repeat (16) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rd32(8'h20, 32'h18, 32'h18);
    repeat (3) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    wr32(8'h28, 32'hFF);
    $display("test interrupt mask done");
    wr32(8'h04, 32'h0);
    wrrd(8'h14, 32'h1234, rnd & 32'hFFFF);
    chk("line enables", {29'h0, drv_a, drv_a_oe, drv_b_oe}, 32'h0);
    rd32(8'h20, 32'h300FF, 32'h10000);
    for (int i = 0; i < 3; i++) begin
      req_a <= !i[0];
      repeat (6) @(posedge clk);
    end
    rd32(8'h20, 32'h2006E, 32'h20062);
    rd32(8'h20, 32'h62, 32'h0);
    $display("test capture loads done");
    wr32(8'h00, 32'h5);
    rd32(8'h10, 32'hFFFF0000, 32'h0, 2);
    repeat (65540) @(posedge clk);
    rd32(8'h20, 32'h10001, 32'h10001);
    wr32(8'h00, 32'h2);
    wr32(8'h00, 32'h4);
    rd32(8'h10, 32'hFFFFFFFF, 32'h0);
    rd32(8'h20, 32'h10000, 32'h0);
    $display("test overflow and clock done");
    summarize();
  end
endmodule : timer_channel_status_regs_test
`default_nettype wire
